// file: inc/pch_pkg.sv
// Constants and types shared by the configuration header register set
package pch_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Configuration offsets (byte addresses of dwords)
    localparam logic [7:0] CFG_MEM_BAR_A   = 8'h10; // Memory window base
    localparam logic [7:0] CFG_BAR_B       = 8'h14; // Memory or I/O base
    localparam logic [7:0] CFG_CAP_PTR     = 8'h34; // Capability pointer
    localparam logic [7:0] CFG_INT_LINE    = 8'h3C; // Line and pin
    localparam logic [7:0] CFG_EXT_INT     = 8'h48; // Ext interrupt ctrl
    localparam logic [7:0] CFG_HOT_SWAP    = 8'h80; // Hot-swap capability

    ////////////////////////////////////////////////////////////////////////
    // Window sizes as low address bits covered
    localparam int MEM_WIN_BITS = 24;              // 16 MB window
    localparam int IO_WIN_BITS  = 8;               // 256-byte window

    ////////////////////////////////////////////////////////////////////////
    // Base address register fields
    localparam int         MEM_PREF_BIT  = 3;      // Prefetchable flag
    localparam int         IO_SPACE_BIT  = 0;      // I/O space flag
    localparam logic [7:0] CAP_PTR_VALUE = 8'h80;  // Points at hot-swap
    localparam logic [7:0] INT_PIN_VALUE = 8'h01;  // Uses pin A

    ////////////////////////////////////////////////////////////////////////
    // External interrupt control and status fields
    localparam int EXT_PEND_BIT = 8;               // Pending, write 1 clear
    localparam int EXT_EN_BIT   = 9;               // Enable

    ////////////////////////////////////////////////////////////////////////
    // Hot-swap register fields
    localparam int         HS_MASK_BIT = 9;        // Enum output mask
    localparam int         HS_LED_BIT  = 11;       // Blue indicator
    localparam int         HS_INS_BIT  = 14;       // Insertion status
    localparam int         HS_EXT_BIT  = 15;       // Extraction status
    localparam logic [7:0] HS_NEXT_PTR = 8'h00;    // End of list
    localparam logic [7:0] HS_CAP_ID   = 8'h06;    // Hot-swap identifier

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000; // Multi-bit stored state
    localparam logic        RST_BIT  = 1'b0;          // Single flags

    ////////////////////////////////////////////////////////////////////////
    // Configuration cycle request carried as one bundle
    typedef struct packed {
        logic        rd;     // Read strobe, one cycle
        logic        wr;     // Write strobe, one cycle
        logic [7:0]  addr;   // Dword-aligned offset
        logic [3:0]  be;     // Byte enables, high active
        logic [31:0] wdata;  // Write data
    } pch_cfg_req_type;

endpackage : pch_pkg

// file: core/pch_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pch_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] rst_value,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;  // First stage, read only by second

    ////////////////////////////////////////////////////////////////////////
    // One chain per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Both stages reset to the idle level given
            always_ff @(posedge clk) begin
                if (rst) begin
                    stage1_reg[i] <= rst_value[i];
                    sync_out[i]   <= rst_value[i];
                end else begin
                    // Second stage is the only reader of the first
                    stage1_reg[i] <= async_in[i];
                    sync_out[i]   <= stage1_reg[i];
                end
            end
        end
    endgenerate

endmodule : pch_sync

// file: core/pch_regs.sv
// Configuration header register set of a PCI target
// Operation
// - Status bits clear only by writing one
// - Memory base bit 0 reads zero
// - Memory base bits 2-1 read 00
// - Memory base bit 3 reads one
// - Memory base size bits read zero
// - Memory hit on address match
// - Size split follows build-time window size
// - Memory base at 10h or 14h
// - I/O base at 14h, bit0 one
// - I/O base bits 7-2 read zero
// - I/O hit on address bits match
// - Capability pointer reads 80h with hot-swap
// - Capability pointer omitted without hot-swap
// - Interrupt line byte is plain storage
// - Interrupt pin byte reads 01h
// - Interrupt register omitted without interrupts
// - Pending bit sets on low input
// - Bit 9 enables external interrupt
// - Bit 11 drives blue LED
// - Hot-swap next pointer reads zero
// - Hot-swap identifier reads 06h
// - Capability-list status follows hot-swap option
`timescale 1ns/10ps
module pch_regs #(
    parameter bit HOT_SWAP_EN = 1'b1,  // Hot-swap capability present
    parameter bit INT_EN      = 1'b1,  // Interrupt support present
    parameter bit MEM_AT_B    = 1'b0,  // Memory base at 14h, not 10h
    parameter bit IO_EN       = 1'b1,  // I/O base present at 14h
    parameter int MEM_BITS    = pch_pkg::MEM_WIN_BITS, // Memory size
    parameter int IO_BITS     = pch_pkg::IO_WIN_BITS   // I/O size
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire pch_pkg::pch_cfg_req_type cfg_req,
    output logic [31:0]                   cfg_rdata,
    output logic                          cfg_rvalid,
    input  wire logic [31:0]              pci_addr,
    output logic                          mem_hit,
    output logic                          io_hit,
    input  wire logic                     external_interrupt_in_n,
    input  wire logic                     insert_evt,
    input  wire logic                     extract_evt,
    output logic                          inta_o,
    output logic                          inta_oe,
    output logic                          enum_o,
    output logic                          enum_oe,
    output logic                          led_blue,
    output logic                          cap_list_status
);
    import pch_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Address select, used by read and write decode
    function automatic logic sel(input logic [7:0] a,
                                 input logic [7:0] off);
        sel = (a[7:2] == off[7:2]);
    endfunction : sel

    // Byte-lane merge of write data into an old value
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (new_v & m) | (old_v & ~m);
    endfunction : merge

    // Mask of writable compare bits above a window size
    function automatic logic [31:0] hi_mask(input int bits);
        hi_mask = 32'hFFFF_FFFF << bits;
    endfunction : hi_mask

    // Lane enable of a single bit position
    function automatic logic lane(input logic [3:0] be, input int bit_n);
        lane = be[bit_n / 8];
    endfunction : lane

    ////////////////////////////////////////////////////////////////////////
    // Build-time constants

    localparam logic [31:0] MEM_MASK = hi_mask(MEM_BITS);
    localparam logic [31:0] IO_MASK  = hi_mask(IO_BITS);
    localparam logic [7:0]  MEM_OFF  = MEM_AT_B ? CFG_BAR_B
                                                : CFG_MEM_BAR_A;
    localparam bit          IO_HERE  = IO_EN && !MEM_AT_B;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [31:0] mem_base_reg;   // Writable memory compare bits
    logic [31:0] io_base_reg;    // Writable I/O compare bits
    logic [7:0]  int_line_reg;   // Interrupt line storage
    logic        ext_pend_reg;   // External interrupt pending
    logic        ext_en_reg;     // External interrupt enable
    logic        hs_mask_reg;    // Enum output mask
    logic        hs_led_reg;     // Blue LED control
    logic        hs_ins_reg;     // Insertion status
    logic        hs_ext_reg;     // Extraction status
    logic [31:0] rdata_next;     // Read mux result
    logic        ext_int_n_s;    // Synchronised interrupt input
    logic        wr;             // Write strobe
    logic [3:0]  be;             // Write byte enables
    logic [31:0] wd;             // Write data

    assign wr = cfg_req.wr;
    assign be = cfg_req.be;
    assign wd = cfg_req.wdata;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser for the external interrupt

    pch_sync #(
        .WIDTH     (1)
    ) u_ext_sync (
        .clk       (clk),
        .rst       (rst),
        .async_in  (external_interrupt_in_n),
        .rst_value (1'b1),
        .sync_out  (ext_int_n_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Memory window base

    // Only the compare bits above the window size are stored
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_base_reg <= RST_WORD;
        end else if (wr && sel(cfg_req.addr, MEM_OFF)) begin
            mem_base_reg <= merge(mem_base_reg, wd, be) & MEM_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // I/O window base

    // Present only when memory base sits at 10h
    always_ff @(posedge clk) begin
        if (rst) begin
            io_base_reg <= RST_WORD;
        end else if (IO_HERE && wr && sel(cfg_req.addr, CFG_BAR_B)) begin
            io_base_reg <= merge(io_base_reg, wd, be) & IO_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address hit decode

    // Compare stored bits against the bus address
    always_comb begin
        mem_hit = ((pci_addr & MEM_MASK) == mem_base_reg);
        io_hit  = IO_HERE &&
                  ((pci_addr & IO_MASK) == io_base_reg);
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt line storage

    // Plain storage, read back only, drives nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            int_line_reg <= RST_WORD[7:0];
        end else if (INT_EN && wr && be[0] &&
                     sel(cfg_req.addr, CFG_INT_LINE)) begin
            int_line_reg <= wd[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External interrupt enable

    // Written directly, one means enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_en_reg <= RST_BIT;
        end else if (wr && lane(be, EXT_EN_BIT) &&
                     sel(cfg_req.addr, CFG_EXT_INT)) begin
            ext_en_reg <= wd[EXT_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External interrupt pending

    // Low input sets; write one clears; set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_pend_reg <= RST_BIT;
        end else if (!ext_int_n_s) begin
            ext_pend_reg <= 1'b1;
        end else if (wr && lane(be, EXT_PEND_BIT) && wd[EXT_PEND_BIT] &&
                     sel(cfg_req.addr, CFG_EXT_INT)) begin
            ext_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin drive

    // Open drain: pull low while pending and enabled
    always_comb begin
        inta_o  = 1'b0;
        inta_oe = INT_EN && ext_pend_reg && ext_en_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Hot-swap control bits

    // Mask and LED are plain writable bits
    always_ff @(posedge clk) begin
        if (rst) begin
            hs_mask_reg <= RST_BIT;
            hs_led_reg  <= RST_BIT;
        end else if (HOT_SWAP_EN && wr && be[1] &&
                     sel(cfg_req.addr, CFG_HOT_SWAP)) begin
            hs_mask_reg <= wd[HS_MASK_BIT];
            hs_led_reg  <= wd[HS_LED_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hot-swap insertion status

    // Event sets; write one clears; set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            hs_ins_reg <= RST_BIT;
        end else if (HOT_SWAP_EN && insert_evt) begin
            hs_ins_reg <= 1'b1;
        end else if (wr && lane(be, HS_INS_BIT) && wd[HS_INS_BIT] &&
                     sel(cfg_req.addr, CFG_HOT_SWAP)) begin
            hs_ins_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hot-swap extraction status

    // Event sets; write one clears; set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            hs_ext_reg <= RST_BIT;
        end else if (HOT_SWAP_EN && extract_evt) begin
            hs_ext_reg <= 1'b1;
        end else if (wr && lane(be, HS_EXT_BIT) && wd[HS_EXT_BIT] &&
                     sel(cfg_req.addr, CFG_HOT_SWAP)) begin
            hs_ext_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hot-swap pin outputs

    // Enum pulled low on pending status unless masked
    always_comb begin
        enum_o   = 1'b0;
        enum_oe  = (hs_ins_reg || hs_ext_reg) && !hs_mask_reg;
        led_blue = hs_led_reg;
    end

    // Status capability-list bit follows the build option
    assign cap_list_status = HOT_SWAP_EN;

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    // Fixed fields are merged in; unmapped offsets read zero
    always_comb begin
        rdata_next = RST_WORD;
        if (sel(cfg_req.addr, MEM_OFF)) begin
            // Bits 2-0 zero, size bits zero, bit 3 set
            rdata_next = mem_base_reg;
            rdata_next[MEM_PREF_BIT] = 1'b1;
        end else if (IO_HERE && sel(cfg_req.addr, CFG_BAR_B)) begin
            // Bit 1 and size bits zero, bit 0 set
            rdata_next = io_base_reg;
            rdata_next[IO_SPACE_BIT] = 1'b1;
        end else if (HOT_SWAP_EN && sel(cfg_req.addr, CFG_CAP_PTR)) begin
            // Absent without hot-swap, so reads zero
            rdata_next[7:0] = CAP_PTR_VALUE;
        end else if (INT_EN && sel(cfg_req.addr, CFG_INT_LINE)) begin
            // Line storage and fixed pin code
            rdata_next[15:0] = {INT_PIN_VALUE, int_line_reg};
        end else if (sel(cfg_req.addr, CFG_EXT_INT)) begin
            // Pending and enable, rest reserved
            rdata_next[EXT_PEND_BIT] = ext_pend_reg;
            rdata_next[EXT_EN_BIT]   = ext_en_reg;
        end else if (HOT_SWAP_EN && sel(cfg_req.addr, CFG_HOT_SWAP)) begin
            // Identifier, list end and control bits
            rdata_next[31:24]       = HS_CAP_ID;
            rdata_next[23:16]       = HS_NEXT_PTR;
            rdata_next[HS_MASK_BIT] = hs_mask_reg;
            rdata_next[HS_LED_BIT]  = hs_led_reg;
            rdata_next[HS_INS_BIT]  = hs_ins_reg;
            rdata_next[HS_EXT_BIT]  = hs_ext_reg;
        end else begin
            // Unmapped offset
            rdata_next = RST_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data register

    // Data captured on the read strobe, valid one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_rdata  <= RST_WORD;
            cfg_rvalid <= RST_BIT;
        end else begin
            cfg_rvalid <= cfg_req.rd;
            if (cfg_req.rd) begin
                cfg_rdata <= rdata_next;
            end
        end
    end

endmodule : pch_regs

// file: sim/pch_regs_assertions.sv
// Concurrent checks on the configuration header register ports
`timescale 1ns/10ps
module pch_regs_assertions
    import pch_pkg::*;
#(
    parameter bit HOT_SWAP_EN = 1'b1  // Hot-swap capability present
) (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire pch_pkg::pch_cfg_req_type cfg_req,
    input wire logic [31:0]              cfg_rdata,
    input wire logic                     cfg_rvalid,
    input wire logic [31:0]              pci_addr,
    input wire logic                     mem_hit,
    input wire logic                     io_hit,
    input wire logic                     external_interrupt_in_n,
    input wire logic                     insert_evt,
    input wire logic                     extract_evt,
    input wire logic                     inta_oe,
    input wire logic                     enum_oe,
    input wire logic                     led_blue,
    input wire logic                     cap_list_status
);
    ////////////////////////////////////////////////////////////////////////
    // Helpers
    wire logic hs_wr;  // Write touching the hot-swap control byte
    assign hs_wr = cfg_req.wr && cfg_req.be[1]
                   && cfg_req.addr[7:2] == CFG_HOT_SWAP[7:2];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Read request to one dword
    sequence s_rd(logic [7:0] a);
        cfg_req.rd && cfg_req.addr[7:2] == a[7:2];
    endsequence

    // Write request covering the given lanes
    sequence s_wr(logic [7:0] a, logic [3:0] lanes);
        cfg_req.wr && cfg_req.addr[7:2] == a[7:2]
        && (cfg_req.be & lanes) == lanes;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Properties
    rd_answer_a: assert property (!$past(rst) |->
        cfg_rvalid == $past(cfg_req.rd))
        else $error("read answer not one cycle after request");
    mem_bar_low_a: assert property (s_rd(CFG_MEM_BAR_A) |=>
        cfg_rdata[23:0] == 24'h000008) else $error("memory base low bits");
    io_bar_low_a: assert property (s_rd(CFG_BAR_B) |=>
        cfg_rdata[7:0] == 8'h01) else $error("io base low bits");
    int_pin_a: assert property (s_rd(CFG_INT_LINE) |=>
        cfg_rdata[15:8] == INT_PIN_VALUE) else $error("interrupt pin byte");
    hs_ident_a: assert property (s_rd(CFG_HOT_SWAP) |=>
        cfg_rdata[31:16] == {HS_CAP_ID, HS_NEXT_PTR})
        else $error("hot-swap id and next pointer");
    mem_hit_a: assert property (s_wr(CFG_MEM_BAR_A, 4'h8) |=>
        mem_hit == (pci_addr[31:24] == $past(cfg_req.wdata[31:24])))
        else $error("memory hit compare");
    io_hit_a: assert property (s_wr(CFG_BAR_B, 4'hE) |=>
        io_hit == (pci_addr[31:8] == $past(cfg_req.wdata[31:8])))
        else $error("io hit compare");
    led_follow_a: assert property (s_wr(CFG_HOT_SWAP, 4'h2) |=>
        led_blue == $past(cfg_req.wdata[HS_LED_BIT])) else $error("led bit");
    cap_status_a: assert property (cap_list_status == HOT_SWAP_EN)
        else $error("capability list status");
    int_clear_a: assert property (external_interrupt_in_n [*3] ##0
        s_wr(CFG_EXT_INT, 4'h2) ##0 cfg_req.wdata[EXT_PEND_BIT]
        |=> ##1 !inta_oe) else $error("interrupt not released on clear");
    enum_cause_a: assert property ($rose(enum_oe) |->
        $past(insert_evt) || $past(extract_evt) || $past(hs_wr))
        else $error("enum output without cause");
endmodule : pch_regs_assertions

// file: sim/pch_host_model.sv
// Host model issuing single-dword configuration cycles
`timescale 1ns/10ps
module pch_host_model
    import pch_pkg::*;
(
    input  wire logic                clk,
    output pch_pkg::pch_cfg_req_type cfg_req,
    input  wire logic [31:0]         cfg_rdata,
    input  wire logic                cfg_rvalid
);
    initial cfg_req = '0;  // Idle from time zero

    // One write, taken at the next edge
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be,
                          input logic [31:0] d);
        @(posedge clk);
        #1;
        cfg_req = '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
        @(posedge clk);
        #1;
        cfg_req.wr = 1'b0;
        cfg_req.wdata = ~d;  // Released data must not linger
        cfg_req.addr = ~a;
    endtask : cfg_wr

    // One read, answer looked at in the cycle after the request
    task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic ok);
        @(posedge clk);
        #1;
        cfg_req.rd = 1'b1;
        cfg_req.addr = a;
        @(posedge clk);
        #1;
        cfg_req.rd = 1'b0;
        cfg_req.addr = ~a;
        ok = cfg_rvalid;
        d = cfg_rdata;
    endtask : cfg_rd
endmodule : pch_host_model

// file: sim/pch_regs_test.sv
// Self-checking bench for the configuration header register set
`timescale 1ns/10ps
module pch_regs_test;
    import pch_pkg::*;

    // Write then read back
    typedef struct packed {
        logic [7:0]  addr;   // Offset
        logic [3:0]  be;     // Lanes
        logic [31:0] wdata;  // Written
        logic [31:0] rexp;   // Expected read
    } pch_row_type;

    logic            clk = 1'b0;              // 100 MHz
    logic            rst = 1'b1;              // Sync reset
    pch_cfg_req_type cfg_req;                 // Host request
    logic [31:0]     cfg_rdata;               // Read data
    logic            cfg_rvalid;              // Read answer
    logic [31:0]     pci_addr = 32'h0;        // Decoded address
    logic            mem_hit;                 // Memory hit
    logic            io_hit;                  // I/O hit
    logic            ext_n = 1'b1;            // Interrupt pin
    logic            insert_evt = 1'b0;       // Insertion pulse
    logic            extract_evt = 1'b0;      // Extraction pulse
    logic            inta_o;                  // Interrupt data
    logic            inta_oe;                 // Interrupt drive
    logic            enum_o;                  // Enum data
    logic            enum_oe;                 // Enum drive
    logic            led_blue;                // Indicator
    logic            cap_list_status;         // Capability status
    int              num_errors = 0;          // Mismatches
    int              n_tests = 0;             // Comparisons
    int              cycles = 0;              // Watchdog

    pch_row_type rows [11] = '{
        '{8'h10, 4'hF, 32'hFFFFFFFF, 32'hFF000008},
        '{8'h10, 4'h7, 32'h00FFFFFF, 32'hFF000008},
        '{8'h14, 4'hF, 32'hFFFFFFFF, 32'hFFFFFF01},
        '{8'h34, 4'hF, 32'hFFFFFFFF, 32'h00000080},
        '{8'h3C, 4'hF, 32'hFFFFFFFF, 32'h000001FF},
        '{8'h3C, 4'h1, 32'h0000005A, 32'h0000015A},
        '{8'h48, 4'hF, 32'hFFFFFDFF, 32'h00000000},
        '{8'h48, 4'h2, 32'h00000200, 32'h00000200},
        '{8'h80, 4'hF, 32'h00000A00, 32'h06000A00},
        '{8'h80, 4'h2, 32'h00000000, 32'h06000000},
        '{8'h40, 4'hF, 32'hFFFFFFFF, 32'h00000000}
    };

    always #5 clk = ~clk;  // Half period

    pch_host_model host_u (.clk(clk), .cfg_req(cfg_req),
                           .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

    pch_regs dut_u (.clk(clk), .rst(rst), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .pci_addr(pci_addr),
        .mem_hit(mem_hit), .io_hit(io_hit), .external_interrupt_in_n(ext_n),
        .insert_evt(insert_evt), .extract_evt(extract_evt), .inta_o(inta_o),
        .inta_oe(inta_oe), .enum_o(enum_o), .enum_oe(enum_oe),
        .led_blue(led_blue), .cap_list_status(cap_list_status));

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Read one dword and compare
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic        ok;
        host_u.cfg_rd(a, d, ok);
        chk("cfg_rvalid", 32'h1, {31'h0, ok});
        chk($sformatf("cfg_rdata at %h", a), e, d);
    endtask : rd_chk

    // Let edges pass, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // Watchdog against a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        tick(2);
        rst = 1'b0;
        foreach (rows[i]) begin
            host_u.cfg_wr(rows[i].addr, rows[i].be, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rexp);
        end
        // Window hits against programmed bases
        host_u.cfg_wr(CFG_MEM_BAR_A, 4'hF, 32'hAB000000);
        host_u.cfg_wr(CFG_BAR_B, 4'hF, 32'h12345600);
        pci_addr = 32'hABCDEF12;
        tick(1);
        chk("mem_hit", 32'h1, {31'h0, mem_hit});
        chk("io_hit", 32'h0, {31'h0, io_hit});
        pci_addr = 32'h123456FF;
        tick(1);
        chk("mem_hit", 32'h0, {31'h0, mem_hit});
        chk("io_hit", 32'h1, {31'h0, io_hit});
        // Interrupt enabled: set, keep on zero write, clear on one
        ext_n = 1'b0;
        tick(5);
        ext_n = 1'b1;
        tick(4);
        chk("inta_oe", 32'h1, {31'h0, inta_oe});
        chk("inta_o", 32'h0, {31'h0, inta_o});
        rd_chk(CFG_EXT_INT, 32'h00000300);
        host_u.cfg_wr(CFG_EXT_INT, 4'h2, 32'h00000200);
        rd_chk(CFG_EXT_INT, 32'h00000300);
        host_u.cfg_wr(CFG_EXT_INT, 4'h2, 32'h00000300);
        tick(2);
        chk("inta_oe", 32'h0, {31'h0, inta_oe});
        rd_chk(CFG_EXT_INT, 32'h00000200);
        // Interrupt disabled: pending sets, pin stays quiet
        host_u.cfg_wr(CFG_EXT_INT, 4'h2, 32'h00000000);
        ext_n = 1'b0;
        tick(5);
        chk("inta_oe", 32'h0, {31'h0, inta_oe});
        ext_n = 1'b1;
        tick(3);
        rd_chk(CFG_EXT_INT, 32'h00000100);
        // Hot-swap events, mask and clear
        insert_evt = 1'b1;
        tick(1);
        insert_evt = 1'b0;
        chk("enum_oe", 32'h1, {31'h0, enum_oe});
        chk("enum_o", 32'h0, {31'h0, enum_o});
        extract_evt = 1'b1;
        tick(1);
        extract_evt = 1'b0;
        rd_chk(CFG_HOT_SWAP, 32'h0600C000);
        host_u.cfg_wr(CFG_HOT_SWAP, 4'h2, 32'h00000200);
        chk("enum_oe", 32'h0, {31'h0, enum_oe});
        host_u.cfg_wr(CFG_HOT_SWAP, 4'h2, 32'h0000C800);
        chk("led_blue", 32'h1, {31'h0, led_blue});
        rd_chk(CFG_HOT_SWAP, 32'h06000800);
        // Reset in mid-run
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        chk("led_blue", 32'h0, {31'h0, led_blue});
        rd_chk(CFG_MEM_BAR_A, 32'h00000008);
        rd_chk(CFG_EXT_INT, 32'h00000000);
        rd_chk(CFG_INT_LINE, 32'h00000100);
        chk("cap_list_status", 32'h1, {31'h0, cap_list_status});
        finish_test();
    end
endmodule : pch_regs_test

bind pch_regs pch_regs_assertions #(.HOT_SWAP_EN(HOT_SWAP_EN)) chk_u (
    .clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .pci_addr(pci_addr), .mem_hit(mem_hit),
    .io_hit(io_hit), .external_interrupt_in_n(external_interrupt_in_n),
    .insert_evt(insert_evt), .extract_evt(extract_evt), .inta_oe(inta_oe),
    .enum_oe(enum_oe), .led_blue(led_blue),
    .cap_list_status(cap_list_status));
